// [spc_pkg.sv]
// shared constants and types for the segment privilege checker
package spc_pkg;
	localparam logic [1:0] PL_MOST  = 2'h0;
	localparam logic [1:0] PL_LEAST = 2'h3;
	localparam logic [1:0] PL_INNER_MAX = 2'h2;

	// access / operation kinds
	typedef enum logic [3:0] {
		SPC_OP_DATA      = 4'h0,
		SPC_OP_IO_PORT   = 4'h1,
		SPC_OP_IO_OTHER  = 4'h2,
		SPC_OP_JMP       = 4'h3,
		SPC_OP_CALL      = 4'h4,
		SPC_OP_RET       = 4'h5,
		SPC_OP_IRET      = 4'h6,
		SPC_OP_INTR      = 4'h7,
		SPC_OP_LOAD_CS   = 4'h8
	} spc_op_t;

	// descriptor kinds
	typedef enum logic [2:0] {
		SPC_DESC_DATA      = 3'h0,
		SPC_DESC_CODE      = 3'h1,
		SPC_DESC_CALL_GATE = 3'h2,
		SPC_DESC_TRAP_GATE = 3'h3,
		SPC_DESC_INT_GATE  = 3'h4,
		SPC_DESC_TASK_SEG  = 3'h5,
		SPC_DESC_TASK_GATE = 3'h6
	} spc_desc_t;

	// descriptor table
	typedef enum logic [1:0] {
		SPC_TBL_GLOBAL = 2'h0,
		SPC_TBL_LOCAL  = 2'h1,
		SPC_TBL_INTR   = 2'h2
	} spc_tbl_t;

	// checker state
	typedef enum logic [1:0] {
		SPC_ST_IDLE  = 2'b00,
		SPC_ST_CHECK = 2'b01,
		SPC_ST_DONE  = 2'b10
	} spc_state_t;
endpackage

// [spc_checker.sv]
// segment privilege checker: privilege, i/o and control transfer checks
`timescale 1ns/10ps
module spc_checker (
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RESETN,
	input  wire logic                CE,
	// mode
	input  wire logic                PROTECTION_ENABLE_BIT,
	input  wire logic [1:0]          IO_PRIVILEGE_FIELD,
	input  wire logic                NESTED_TASK_FLAG,
	input  wire logic                TASK_SEG_32,
	// request
	input  wire logic                REQ_VALID,
	input  wire spc_pkg::spc_op_t    REQ_OP,
	input  wire logic [1:0]          REQUESTED_PRIVILEGE_LEVEL,
	input  wire logic [1:0]          DESCRIPTOR_PRIVILEGE_LEVEL,
	input  wire spc_pkg::spc_desc_t  REQ_DESC,
	input  wire spc_pkg::spc_tbl_t   REQ_TABLE,
	input  wire logic [1:0]          TARGET_CODE_PRIVILEGE,
	input  wire logic                IO_BITMAP_ALLOW,
	// stack values from task segment, return frame and current stack
	input  wire logic [15:0]         TSS_STACK_SEG,
	input  wire logic [31:0]         TSS_STACK_PTR,
	input  wire logic [15:0]         SAVED_STACK_SEG,
	input  wire logic [31:0]         SAVED_STACK_PTR,
	input  wire logic [15:0]         CUR_STACK_SEG,
	input  wire logic [31:0]         CUR_STACK_PTR,
	// result
	output logic                     RESP_VALID,
	output logic                     GP_FAULT,
	output logic                     PROTECTED_MODE,
	output logic [1:0]               CURRENT_PRIVILEGE_LEVEL,
	output logic [1:0]               EFFECTIVE_PRIVILEGE_LEVEL,
	output logic                     STACK_LOAD,
	output logic [15:0]              NEW_STACK_SEG,
	output logic [31:0]              NEW_STACK_PTR,
	output logic                     PUSH_OLD_STACK,
	output logic [15:0]              PUSH_STACK_SEG,
	output logic [31:0]              PUSH_STACK_PTR
);

	////////////////////////////////////////////////////////////////////////////////
	// reset synchroniser and pin input synchronisers
	logic       rst_meta;
	logic       rst_n;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// outside-domain levels: enable bit, nested flag, segment width
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else if (CE) begin
			pin_meta <= {TASK_SEG_32, NESTED_TASK_FLAG, PROTECTION_ENABLE_BIT};
			pin_sync <= pin_meta;
		end
	end

	logic pe_sync;
	logic nt_sync;
	logic ts32_sync;
	assign pe_sync   = pin_sync[0];
	assign nt_sync   = pin_sync[1];
	assign ts32_sync = pin_sync[2];

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	function automatic logic [1:0] pl_max(input logic [1:0] a, input logic [1:0] b);
		pl_max = (a > b) ? a : b;
	endfunction

	function automatic logic is_gate(input spc_pkg::spc_desc_t d);
		is_gate = (d == spc_pkg::SPC_DESC_CALL_GATE) || (d == spc_pkg::SPC_DESC_TRAP_GATE) ||
			(d == spc_pkg::SPC_DESC_INT_GATE) || (d == spc_pkg::SPC_DESC_TASK_GATE);
	endfunction

	function automatic logic in_gl(input spc_pkg::spc_tbl_t t);
		in_gl = (t == spc_pkg::SPC_TBL_GLOBAL) || (t == spc_pkg::SPC_TBL_LOCAL);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// mode and hidden current privilege

	logic       prot;
	logic [1:0] cpl_hidden;

	// real mode after reset, protected once enable bit set
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			prot <= 1'b0;
		else if (CE)
			prot <= pe_sync;
	end

	// real mode privilege is level 0
	logic [1:0] current_privilege_level;
	assign current_privilege_level = prot ? cpl_hidden : spc_pkg::PL_MOST;

	////////////////////////////////////////////////////////////////////////////////
	// combinational check of the captured request

	spc_pkg::spc_state_t state;
	spc_pkg::spc_op_t    op_q;
	spc_pkg::spc_desc_t  desc_q;
	spc_pkg::spc_tbl_t   tbl_q;
	logic [1:0]          rpl_q;
	logic [1:0]          dpl_q;
	logic [1:0]          tgt_q;
	logic                bitmap_q;

	logic [1:0] effective_privilege_level;
	logic       fault;
	logic       cpl_change;
	logic [1:0] next_cpl;
	logic       inward;
	logic       outward;

	// effective privilege from requested and current levels
	assign effective_privilege_level = pl_max(rpl_q, current_privilege_level);

	always_comb begin
		fault      = 1'b0;
		cpl_change = 1'b0;
		next_cpl   = current_privilege_level;
		inward     = 1'b0;
		outward    = 1'b0;
		case (op_q)
			// descriptor privilege is the access floor
			// effective must not exceed descriptor privilege
			// data only from equal or higher privilege
			spc_pkg::SPC_OP_DATA, spc_pkg::SPC_OP_LOAD_CS: begin
				fault = (effective_privilege_level > dpl_q);
			end
			// pass when current within i/o field
			spc_pkg::SPC_OP_IO_PORT: begin
				if (prot && (current_privilege_level > IO_PRIVILEGE_FIELD))
					fault = !(ts32_sync && bitmap_q);
			end
			spc_pkg::SPC_OP_IO_OTHER: begin
				fault = prot && (current_privilege_level > IO_PRIVILEGE_FIELD);
			end
			spc_pkg::SPC_OP_JMP, spc_pkg::SPC_OP_CALL: begin
				if (desc_q == spc_pkg::SPC_DESC_CODE) begin
					fault = !in_gl(tbl_q) || (dpl_q != current_privilege_level) || (effective_privilege_level > dpl_q);
				end else if (desc_q == spc_pkg::SPC_DESC_CALL_GATE && op_q == spc_pkg::SPC_OP_CALL) begin
					// gate enters same or higher only
					// gate needs effective within gate privilege
					fault = !in_gl(tbl_q) || (effective_privilege_level > dpl_q) || (tgt_q > current_privilege_level);
					// call from equal or lower privilege
					cpl_change = !fault && (tgt_q != current_privilege_level);
					next_cpl   = tgt_q;
					inward     = cpl_change;
				end else if (desc_q == spc_pkg::SPC_DESC_TASK_SEG) begin
					// task switch through global task segment
					fault = (tbl_q != spc_pkg::SPC_TBL_GLOBAL) || (effective_privilege_level > dpl_q);
					cpl_change = !fault && (tgt_q != current_privilege_level);
					next_cpl   = tgt_q;
				end else if (desc_q == spc_pkg::SPC_DESC_TASK_GATE) begin
					fault = !in_gl(tbl_q) || (effective_privilege_level > dpl_q);
					cpl_change = !fault && (tgt_q != current_privilege_level);
					next_cpl   = tgt_q;
				end else begin
					fault = 1'b1;
				end
			end
			spc_pkg::SPC_OP_RET, spc_pkg::SPC_OP_IRET: begin
				if (op_q == spc_pkg::SPC_OP_IRET && nt_sync) begin
					// nested iret uses a task gate
					fault = (desc_q != spc_pkg::SPC_DESC_TASK_GATE);
					cpl_change = !fault && (tgt_q != current_privilege_level);
					next_cpl   = tgt_q;
				end else begin
					// returns need a code segment, same or outer level
					fault = (desc_q != spc_pkg::SPC_DESC_CODE) || !in_gl(tbl_q) || (rpl_q < current_privilege_level);
					cpl_change = !fault && (rpl_q != current_privilege_level);
					next_cpl   = rpl_q;
					outward    = cpl_change;
				end
			end
			spc_pkg::SPC_OP_INTR: begin
				if (desc_q == spc_pkg::SPC_DESC_TRAP_GATE || desc_q == spc_pkg::SPC_DESC_INT_GATE) begin
					fault = (tbl_q != spc_pkg::SPC_TBL_INTR) || (tgt_q > current_privilege_level);
					cpl_change = !fault && (tgt_q != current_privilege_level);
					next_cpl   = tgt_q;
					inward     = cpl_change;
				end else if (desc_q == spc_pkg::SPC_DESC_TASK_GATE) begin
					fault = (tbl_q != spc_pkg::SPC_TBL_INTR);
					cpl_change = !fault && (tgt_q != current_privilege_level);
					next_cpl   = tgt_q;
				end else begin
					fault = 1'b1;
				end
			end
			default: begin
				fault = 1'b1;
			end
		endcase
		// real mode performs no protection checks and no privilege change
		if (!prot) begin
			fault      = 1'b0;
			cpl_change = 1'b0;
			inward     = 1'b0;
			outward    = 1'b0;
		end
		// only levels 0..2 have inner stacks
		if (next_cpl > spc_pkg::PL_INNER_MAX)
			inward = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// request sequencer

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state    <= spc_pkg::SPC_ST_IDLE;
			op_q     <= spc_pkg::SPC_OP_DATA;
			desc_q   <= spc_pkg::SPC_DESC_DATA;
			tbl_q    <= spc_pkg::SPC_TBL_GLOBAL;
			rpl_q    <= spc_pkg::PL_MOST;
			dpl_q    <= spc_pkg::PL_MOST;
			tgt_q    <= spc_pkg::PL_MOST;
			bitmap_q <= 1'b0;
		end else if (CE) begin
			case (state)
				spc_pkg::SPC_ST_IDLE: begin
					if (REQ_VALID) begin
						op_q     <= REQ_OP;
						desc_q   <= REQ_DESC;
						tbl_q    <= REQ_TABLE;
						rpl_q    <= REQUESTED_PRIVILEGE_LEVEL;
						dpl_q    <= DESCRIPTOR_PRIVILEGE_LEVEL;
						tgt_q    <= TARGET_CODE_PRIVILEGE;
						bitmap_q <= IO_BITMAP_ALLOW;
						state    <= spc_pkg::SPC_ST_CHECK;
					end
				end
				spc_pkg::SPC_ST_CHECK: begin
					state <= spc_pkg::SPC_ST_DONE;
				end
				spc_pkg::SPC_ST_DONE: begin
					state <= spc_pkg::SPC_ST_IDLE;
				end
				default: begin
					state <= spc_pkg::SPC_ST_IDLE;
				end
			endcase
		end
	end

	logic checking;
	assign checking = (state == spc_pkg::SPC_ST_CHECK);

	////////////////////////////////////////////////////////////////////////////////
	// hidden current privilege update

	// hidden privilege follows the active code segment
	// updated on gate, task or return transfers, and cleared to level 0 in real mode
	// never updated on a faulting request
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			cpl_hidden <= spc_pkg::PL_MOST;
		else if (CE) begin
			if (!prot)
				cpl_hidden <= spc_pkg::PL_MOST;
			else if (checking && !fault && cpl_change)
				cpl_hidden <= next_cpl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// result outputs

	// one fault pulse per offending request
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			RESP_VALID                <= 1'b0;
			GP_FAULT                  <= 1'b0;
			EFFECTIVE_PRIVILEGE_LEVEL <= spc_pkg::PL_MOST;
		end else if (CE) begin
			RESP_VALID <= checking;
			GP_FAULT   <= checking && fault;
			if (checking)
				EFFECTIVE_PRIVILEGE_LEVEL <= effective_privilege_level;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PROTECTED_MODE          <= 1'b0;
			CURRENT_PRIVILEGE_LEVEL <= spc_pkg::PL_MOST;
		end else if (CE) begin
			PROTECTED_MODE          <= prot;
			CURRENT_PRIVILEGE_LEVEL <= current_privilege_level;
		end
	end

	// inward change loads task-segment stack and pushes old one
	// outward return restores the saved stack
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			STACK_LOAD     <= 1'b0;
			PUSH_OLD_STACK <= 1'b0;
			NEW_STACK_SEG  <= 16'h0000;
			NEW_STACK_PTR  <= 32'h0000_0000;
			PUSH_STACK_SEG <= 16'h0000;
			PUSH_STACK_PTR <= 32'h0000_0000;
		end else if (CE) begin
			STACK_LOAD     <= checking && !fault && (inward || outward);
			PUSH_OLD_STACK <= checking && !fault && inward;
			if (checking && !fault && inward) begin
				NEW_STACK_SEG  <= TSS_STACK_SEG;
				NEW_STACK_PTR  <= TSS_STACK_PTR;
				PUSH_STACK_SEG <= CUR_STACK_SEG;
				PUSH_STACK_PTR <= CUR_STACK_PTR;
			end else if (checking && !fault && outward) begin
				NEW_STACK_SEG <= SAVED_STACK_SEG;
				NEW_STACK_PTR <= SAVED_STACK_PTR;
			end
		end
	end

endmodule

// [spc_core_model.sv]
// core-side model supplying stack values to the privilege checker
`timescale 1ns/10ps
module spc_core_model (
	// value source
	input  wire logic [31:0] seed,
	// stack values
	output logic      [15:0] tss_seg,
	output logic      [31:0] tss_ptr,
	output logic      [15:0] saved_seg,
	output logic      [31:0] saved_ptr,
	output logic      [15:0] cur_seg,
	output logic      [31:0] cur_ptr
);
	// each stack gets a distinct value so a wrong pick shows
	always_comb begin
		tss_seg = seed[15:0];
		tss_ptr = seed;
		saved_seg = ~seed[15:0];
		saved_ptr = ~seed;
		cur_seg = seed[31:16];
		cur_ptr = seed + 32'h1;
	end
endmodule

// [spc_checker_assertions.sv]
// timing and privilege state assertions on the checker ports
`timescale 1ns/10ps
module spc_checker_assertions (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RESETN,
	// watched ports
	input wire logic        REQ_VALID,
	input wire logic        PROTECTED_MODE,
	input wire logic        RESP_VALID,
	input wire logic        GP_FAULT,
	input wire logic        STACK_LOAD,
	input wire logic        PUSH_OLD_STACK,
	input wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL,
	input wire logic [31:0] NEW_STACK_PTR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_fault_with_resp: assert property (GP_FAULT |-> RESP_VALID) else $error("fault without result");
	a_resp_pulse: assert property (RESP_VALID |=> !RESP_VALID) else $error("result longer than a cycle");
	a_resp_latency: assert property (RESP_VALID |-> $past(REQ_VALID, 2)) else $error("result without request");
	a_load_with_resp: assert property (STACK_LOAD |-> RESP_VALID && !GP_FAULT) else $error("stray stack load");
	a_push_with_load: assert property (PUSH_OLD_STACK |-> STACK_LOAD) else $error("push without load");
	a_real_no_fault: assert property (RESP_VALID && !PROTECTED_MODE && $past(!PROTECTED_MODE, 3) |-> !GP_FAULT)
		else $error("fault in real mode");
	a_real_level_zero: assert property (!PROTECTED_MODE |-> CURRENT_PRIVILEGE_LEVEL == 2'h0)
		else $error("level not zero in real mode");
	a_level_hold: assert property (!$past(RESP_VALID) || $past(GP_FAULT) |-> $stable(CURRENT_PRIVILEGE_LEVEL))
		else $error("level changed outside transfer");
	a_stack_on_load: assert property ($changed(NEW_STACK_PTR) |-> STACK_LOAD) else $error("stack moved without load");
endmodule

// [segment_privilege_checker_test.sv]
// self-checking bench for the segment privilege checker
`timescale 1ns/10ps
module segment_privilege_checker_test;
	logic CLK = 1'b0, RESETN = 1'b0, ce = 1'b1, pe = 1'b0, nt = 1'b0, ts32 = 1'b0, bmp = 1'b0, req = 1'b0;
	logic [1:0] requested_privilege_level = 2'h0, descriptor_privilege_level = 2'h0, tgt = 2'h0, io_privilege_field = 2'h0;
	logic [31:0] seed = 32'h0;
	spc_pkg::spc_op_t op = spc_pkg::SPC_OP_DATA;
	spc_pkg::spc_desc_t desc = spc_pkg::SPC_DESC_DATA;
	spc_pkg::spc_tbl_t tbl = spc_pkg::SPC_TBL_GLOBAL;
	wire logic [15:0] tss_seg, saved_seg, cur_seg, NEW_STACK_SEG, PUSH_STACK_SEG;
	wire logic [31:0] tss_ptr, saved_ptr, cur_ptr, NEW_STACK_PTR, PUSH_STACK_PTR;
	wire logic RESP_VALID, GP_FAULT, PROTECTED_MODE, STACK_LOAD, PUSH_OLD_STACK;
	wire logic [1:0] CURRENT_PRIVILEGE_LEVEL, EFFECTIVE_PRIVILEGE_LEVEL;
	int n_errors = 0, cmp_count = 0, cpl_m = 0, pm_m = 0;
	always #2 CLK = ~CLK;
	spc_core_model i_core (.seed(seed), .tss_seg(tss_seg), .tss_ptr(tss_ptr), .saved_seg(saved_seg),
		.saved_ptr(saved_ptr), .cur_seg(cur_seg), .cur_ptr(cur_ptr));
	spc_checker i_dut (.CLK(CLK), .RESETN(RESETN), .CE(ce), .PROTECTION_ENABLE_BIT(pe),
		.IO_PRIVILEGE_FIELD(io_privilege_field), .NESTED_TASK_FLAG(nt), .TASK_SEG_32(ts32), .REQ_VALID(req), .REQ_OP(op),
		.REQUESTED_PRIVILEGE_LEVEL(requested_privilege_level), .DESCRIPTOR_PRIVILEGE_LEVEL(descriptor_privilege_level), .REQ_DESC(desc), .REQ_TABLE(tbl),
		.TARGET_CODE_PRIVILEGE(tgt), .IO_BITMAP_ALLOW(bmp), .TSS_STACK_SEG(tss_seg), .TSS_STACK_PTR(tss_ptr),
		.SAVED_STACK_SEG(saved_seg), .SAVED_STACK_PTR(saved_ptr), .CUR_STACK_SEG(cur_seg),
		.CUR_STACK_PTR(cur_ptr), .RESP_VALID(RESP_VALID), .GP_FAULT(GP_FAULT), .PROTECTED_MODE(PROTECTED_MODE),
		.CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .EFFECTIVE_PRIVILEGE_LEVEL(EFFECTIVE_PRIVILEGE_LEVEL),
		.STACK_LOAD(STACK_LOAD), .NEW_STACK_SEG(NEW_STACK_SEG), .NEW_STACK_PTR(NEW_STACK_PTR),
		.PUSH_OLD_STACK(PUSH_OLD_STACK), .PUSH_STACK_SEG(PUSH_STACK_SEG), .PUSH_STACK_PTR(PUSH_STACK_PTR));
	////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one request; ops 0 data 1 port 2 other-io 3 jmp 4 call 5 ret 6 iret 7 intr
	// descs 0 data 1 code 2 call gate 3 trap gate 4 int gate 5 task seg 6 task gate; tables 0 gl 1 local 2 intr
	task automatic run(input int o, input int d, input int tb, input int r, input int dp, input int t);
		int effective_privilege_level, f = 0, ld = 0, ps = 0, nc, tk = 0;
		effective_privilege_level = (r > cpl_m) ? r : cpl_m;
		nc = cpl_m;
		if (pm_m != 0) begin
			case (o)
				0: f = d != 0 || effective_privilege_level > dp;
				1: f = cpl_m > io_privilege_field && !(ts32 && bmp);
				2: f = cpl_m > io_privilege_field;
				3, 4: begin
					nc = (d == 1) ? cpl_m : t;
					tk = d == 5 || d == 6;
					if (d == 1) f = tb > 1 || dp != cpl_m || effective_privilege_level > dp;
					else if (d == 2 && o == 4) f = tb > 1 || effective_privilege_level > dp || t > cpl_m;
					else if (tk != 0) f = ((d == 5) ? tb != 0 : tb > 1) || effective_privilege_level > dp;
					else f = 1;
				end
				5, 6: begin
					tk = o == 6 && nt;
					nc = (tk != 0) ? t : r;
					f = (tk != 0) ? d != 6 : d != 1 || tb > 1 || r < cpl_m;
				end
				7: begin
					nc = t;
					tk = d == 6;
					if (d == 3 || d == 4) f = tb != 2 || t > cpl_m;
					else f = tk == 0 || tb != 2;
				end
				default: f = 1;
			endcase
			if (f != 0) nc = cpl_m;
			ld = tk == 0 && nc != cpl_m;
			ps = ld && nc < cpl_m;
		end
		step(1);
		seed = $urandom;
		op = spc_pkg::spc_op_t'(o);
		desc = spc_pkg::spc_desc_t'(d);
		tbl = spc_pkg::spc_tbl_t'(tb);
		{requested_privilege_level, descriptor_privilege_level, tgt} = {2'(r), 2'(dp), 2'(t)};
		req = 1'b1;
		step(1);
		req = 1'b0;
		step(1);
		chk(RESP_VALID === 1'b1 && GP_FAULT === 1'(f) && STACK_LOAD === 1'(ld) && PUSH_OLD_STACK === 1'(ps), "result");
		if (ld) chk(NEW_STACK_PTR === (ps ? seed : ~seed) && NEW_STACK_SEG === (ps ? seed[15:0] : ~seed[15:0]), "new stack");
		if (ps) chk(PUSH_STACK_PTR === seed + 32'h1 && PUSH_STACK_SEG === seed[31:16], "pushed stack");
		step(1);
		chk(CURRENT_PRIVILEGE_LEVEL === 2'(nc), "current level");
		if (pm_m != 0 && o == 0) chk(EFFECTIVE_PRIVILEGE_LEVEL === 2'(effective_privilege_level), "effective level");
		cpl_m = nc;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = $urandom(32'hef86);
		step(10);
		RESETN = 1'b1;
		step(3);
		run(0, 0, 0, 3, 0, 0);
		run(5, 1, 0, 3, 3, 0);
		$display("real mode test done");
		pe = 1'b1;
		for (int i = 0; i < 10 && PROTECTED_MODE !== 1'b1; i++) step(1);
		chk(PROTECTED_MODE === 1'b1 && CURRENT_PRIVILEGE_LEVEL === 2'h0, "protected mode entry");
		if (n_errors > 0) end_of_test();
		pm_m = 1;
		repeat (8) run(0, 0, 0, $urandom % 4, $urandom % 4, 0);
		run(5, 1, 0, 3, 3, 0);
		repeat (8) run(0, 0, 0, $urandom % 4, $urandom % 4, 0);
		$display("data access test done");
		for (int k = 0; k < 4; k++) begin
			{bmp, ts32} = 2'(k);
			step(3);
			for (int i = 0; i < 4; i++) begin
				io_privilege_field = 2'(i);
				run(1, 0, 0, 0, 0, 0);
				run(2, 0, 0, 0, 0, 0);
			end
		end
		$display("io test done");
		run(4, 2, 0, 3, 2, 1);
		run(4, 2, 0, 3, 3, 3);
		run(4, 2, 0, 0, 3, 1);
		run(5, 1, 0, 0, 0, 0);
		ce = 1'b0;
		req = 1'b1;
		step(3);
		chk(RESP_VALID === 1'b0 && CURRENT_PRIVILEGE_LEVEL === 2'(cpl_m), "frozen by clock enable");
		req = 1'b0;
		step(1);
		ce = 1'b1;
		$display("gate test done");
		run(7, 1, 2, 0, 3, 0);
		run(3, 0, 0, 0, 3, 0);
		run(4, 0, 0, 0, 3, 0);
		run(5, 2, 0, 3, 3, 0);
		run(3, 5, 1, 0, 3, 0);
		run(3, 5, 0, 0, 3, 2);
		run(7, 4, 2, 0, 0, 0);
		nt = 1'b1;
		step(3);
		run(6, 1, 0, 3, 3, 0);
		run(6, 6, 2, 0, 3, 2);
		run(5, 1, 0, 3, 3, 0);
		$display("descriptor test done");
		end_of_test();
	end
endmodule
bind spc_checker spc_checker_assertions i_chk (.CLK(CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
	.PROTECTED_MODE(PROTECTED_MODE), .RESP_VALID(RESP_VALID), .GP_FAULT(GP_FAULT), .STACK_LOAD(STACK_LOAD),
	.PUSH_OLD_STACK(PUSH_OLD_STACK), .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .NEW_STACK_PTR(NEW_STACK_PTR));
